// >>> common/sgs_pkg.sv
// Purpose: constants shared by the setting group selector files
// Assumes: apb register map with one aligned 32-bit word per register
// Notes:   group indices are 0..7 for groups one..eight

package sgs_pkg;

    // ------------------------------------------------------------
    // sizes and encodings
    // ------------------------------------------------------------
    localparam int unsigned NGROUP = 8;
    localparam int unsigned IDX_W = 3;
    localparam int unsigned SEL_W = 4;
    // selection codes: 0 is none, 1..8 are groups one..eight
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [3:0] SEL_MAX = 4'h8;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OVR = 8'h04;
    localparam logic [7:0] ADDR_REMOTE = 8'h08;
    localparam logic [7:0] ADDR_ACTIVE = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned CTRL_OVR_BIT = 0;
    localparam int unsigned CTRL_USED_LSB = 4;
    localparam int unsigned ACT_SRC_LSB = 4;
    localparam int unsigned ST_LOWER_BIT = 0;
    localparam int unsigned ST_NOTCFG_BIT = 1;
    localparam int unsigned ST_OVRFAIL_BIT = 2;
    localparam int unsigned ST_W = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0] RST_USED = 3'h0;
    localparam logic [2:0] RST_ACTIVE = 3'h0;
    localparam logic RST_OVR_EN = 1'b0;

    // source of the last group change
    typedef enum logic [1:0] {
        SRC_RESET = 2'b00,
        SRC_INPUT = 2'b01,
        SRC_REMOTE = 2'b10,
        SRC_OVERRIDE = 2'b11
    } sgs_src_type;

endpackage

// >>> design/sgs_req_sync.sv
// Purpose: synchronise the eight group request pins, find rising edges
// Assumes: pins are asynchronous to clk_i
// Notes:   a pulse must be high for at least two clock periods

`timescale 1ns/1ps

module sgs_req_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // raw request pins
    input wire logic [7:0] req_i,
    // synchronised level and one-cycle rise
    output logic [7:0] level_o,
    output logic [7:0] rise_o
);

    // ------------------------------------------------------------
    // two-stage synchroniser plus edge history
    // ------------------------------------------------------------
    logic [7:0] meta_r;
    logic [7:0] sync_r;
    logic [7:0] prev_r;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            meta_r <= 8'h00;
            sync_r <= 8'h00;
        end else begin
            meta_r <= req_i;
            sync_r <= meta_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            prev_r <= 8'h00;
        end else begin
            prev_r <= sync_r;
        end
    end

    assign level_o = sync_r;
    assign rise_o = sync_r & ~prev_r;

endmodule

// >>> design/sgs_selector.sv
// Purpose: choose the active setting group from inputs, remote, override
// Assumes: apb slave with zero wait states, pins sampled via sgs_req_sync
// Notes:   parameter storage of each group lives outside this block
//
// How it works
// - active group reported as one of eight, group one after reset
// - override target holds none or group one to eight, none at reset
// - override enabled makes a configured target active, bypassing requests
// - after override release the last group stays until another request
// - override target applied only if configured and override enabled
// - override enable resets off, blocks local control until cleared
// - on override release a static level request takes over at once
// - used-groups setting enables groups one to N, default one only
// - newly enabled groups get an initialise-to-defaults pulse
// - remote change request holds none or groups, default none
// - remote request below an asserted input level is rejected
// - each request input works by pulse or by static level
// - priority runs from group one highest to group eight lowest
// - static group one level makes every other request ignored
// - static level on group N blocks all lower groups
// - static group eight level blocks nothing
// - simultaneous requests pick the highest priority group
// - pulse-selected group stays active until another request
// - with only group one enabled the selection stays at group one
//
// Decided for this implementation: register access over APB and the placing of the registers.

`timescale 1ns/1ps

module sgs_selector (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // group request pins
    input wire logic [7:0] group_req_i,
    // selection results
    output logic [2:0] active_group_o,
    output logic override_active_o,
    output logic [7:0] used_mask_o,
    output logic [7:0] init_group_o
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // priority pick, lowest index wins; bit 3 flags a hit
    function automatic logic [3:0] first_set(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int k = 7; k >= 0; k--) begin
            if (v[k]) begin
                r = {1'b1, 3'(k)};
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] used_mask(input logic [2:0] n);
        logic [7:0] m;
        m = 8'h00;
        for (int k = 0; k < 8; k++) begin
            m[k] = (3'(k) <= n);
        end
        return m;
    endfunction

    function automatic logic sel_valid(input logic [3:0] s);
        return (s != sgs_pkg::SEL_NONE) && (s <= sgs_pkg::SEL_MAX);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic ovr_en_r;
    logic [2:0] used_r;
    logic [3:0] ovr_sel_r;
    logic [3:0] remote_sel_r;
    logic [2:0] active_r;
    sgs_pkg::sgs_src_type src_r;
    logic [2:0] status_r;
    logic [7:0] init_r;
    logic [31:0] rdata_r;
    logic slverr_r;

    logic [7:0] level;
    logic [7:0] rise;
    logic [7:0] en_mask;
    logic [7:0] lvl;
    logic [7:0] req;
    logic [3:0] hi_lvl;
    logic [3:0] win;
    logic wr;
    logic wr_ctrl;
    logic wr_ovr;
    logic rem_wr;
    logic [2:0] rem_idx;
    logic [2:0] ovr_idx;
    logic rem_range;
    logic rem_lower;
    logic rem_accept;
    logic ovr_ok;
    logic [2:0] active_nxt;
    sgs_pkg::sgs_src_type src_nxt;
    logic [2:0] status_set;

    sgs_req_sync u_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .req_i(group_req_i),
        .level_o(level),
        .rise_o(rise)
    );

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign wr = psel_i && penable_i && pwrite_i && pstrb_i[0];
    assign wr_ctrl = wr && (paddr_i == sgs_pkg::ADDR_CTRL);
    assign wr_ovr = wr && (paddr_i == sgs_pkg::ADDR_OVR);
    assign rem_wr = wr && (paddr_i == sgs_pkg::ADDR_REMOTE);

    // ------------------------------------------------------------
    // request resolution
    // ------------------------------------------------------------
    // enabled groups
    assign en_mask = used_mask(used_r);
    // drop requests beyond the enabled count
    assign lvl = level & en_mask;
    assign hi_lvl = first_set(lvl);
    assign rem_idx = 3'(pwdata_i[3:0] - 4'h1);
    assign ovr_idx = 3'(ovr_sel_r - 4'h1);
    assign rem_range = sel_valid(pwdata_i[3:0]);
    assign rem_lower = hi_lvl[3] && (hi_lvl[2:0] < rem_idx);
    assign rem_accept = rem_wr && rem_range && en_mask[rem_idx]
        && !rem_lower && !ovr_en_r;
    assign req = lvl | (rise & en_mask)
        | (rem_accept ? (8'h01 << rem_idx) : 8'h00);
    // highest priority wins; a held level keeps requesting
    // which is what blocks the lower groups
    assign win = first_set(req);
    // only a configured target while override is enabled
    assign ovr_ok = ovr_en_r && sel_valid(ovr_sel_r) && en_mask[ovr_idx];

    always_comb begin
        active_nxt = active_r;
        src_nxt = src_r;
        if (used_r == 3'h0) begin
            active_nxt = 3'h0;
            src_nxt = sgs_pkg::SRC_RESET;
        end else if (ovr_en_r) begin
            if (ovr_ok) begin
                active_nxt = ovr_idx;
                src_nxt = sgs_pkg::SRC_OVERRIDE;
            end
        end else if (win[3]) begin
            // a held level retakes control after release
            active_nxt = win[2:0];
            src_nxt = (rem_accept && win[2:0] == rem_idx)
                ? sgs_pkg::SRC_REMOTE : sgs_pkg::SRC_INPUT;
        end else if (!en_mask[active_r]) begin
            // group removed by lowering the count
            active_nxt = 3'h0;
            src_nxt = sgs_pkg::SRC_RESET;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            active_r <= sgs_pkg::RST_ACTIVE;
            src_r <= sgs_pkg::SRC_RESET;
        end else begin
            active_r <= active_nxt;
            src_r <= src_nxt;
        end
    end

    // ------------------------------------------------------------
    // settings
    // ------------------------------------------------------------
    // override stays until software clears it
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ovr_en_r <= sgs_pkg::RST_OVR_EN;
            used_r <= sgs_pkg::RST_USED;
        end else if (wr_ctrl) begin
            ovr_en_r <= pwdata_i[sgs_pkg::CTRL_OVR_BIT];
            used_r <= pwdata_i[sgs_pkg::CTRL_USED_LSB +: 3];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ovr_sel_r <= sgs_pkg::SEL_NONE;
            remote_sel_r <= sgs_pkg::SEL_NONE;
        end else begin
            if (wr_ovr) begin
                ovr_sel_r <= pwdata_i[3:0];
            end
            if (rem_wr) begin
                remote_sel_r <= pwdata_i[3:0];
            end
        end
    end

    // one-cycle pulse for each newly enabled group
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            init_r <= 8'h00;
        end else if (wr_ctrl) begin
            init_r <= used_mask(pwdata_i[sgs_pkg::CTRL_USED_LSB +: 3])
                & ~en_mask;
        end else begin
            init_r <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // sticky failure flags, write one to clear, set wins
    // ------------------------------------------------------------
    always_comb begin
        status_set = 3'h0;
        status_set[sgs_pkg::ST_LOWER_BIT] = rem_wr && rem_range
            && en_mask[rem_idx] && rem_lower && !ovr_en_r;
        status_set[sgs_pkg::ST_NOTCFG_BIT] =
            (rem_wr && rem_range && !en_mask[rem_idx])
            || (ovr_en_r && sel_valid(ovr_sel_r) && !en_mask[ovr_idx]);
        // force request without override enabled, or remote under it
        status_set[sgs_pkg::ST_OVRFAIL_BIT] =
            (wr_ovr && sel_valid(pwdata_i[3:0]) && !ovr_en_r)
            || (rem_wr && rem_range && ovr_en_r);
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            status_r <= 3'h0;
        end else if (wr && paddr_i == sgs_pkg::ADDR_STATUS) begin
            status_r <= (status_r & ~pwdata_i[2:0]) | status_set;
        end else begin
            status_r <= status_r | status_set;
        end
    end

    // ------------------------------------------------------------
    // read data, captured in the setup cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_r <= 32'h0000_0000;
            slverr_r <= 1'b0;
        end else if (psel_i && !penable_i) begin
            rdata_r <= 32'h0000_0000;
            slverr_r <= 1'b0;
            case (paddr_i)
                sgs_pkg::ADDR_CTRL: begin
                    rdata_r[sgs_pkg::CTRL_OVR_BIT] <= ovr_en_r;
                    rdata_r[sgs_pkg::CTRL_USED_LSB +: 3] <= used_r;
                end
                sgs_pkg::ADDR_OVR: begin
                    rdata_r[3:0] <= ovr_sel_r;
                end
                sgs_pkg::ADDR_REMOTE: begin
                    rdata_r[3:0] <= remote_sel_r;
                end
                sgs_pkg::ADDR_ACTIVE: begin
                    rdata_r[2:0] <= active_r;
                    rdata_r[sgs_pkg::ACT_SRC_LSB +: 2] <= src_r;
                end
                sgs_pkg::ADDR_STATUS: begin
                    rdata_r[2:0] <= status_r;
                end
                default: begin
                    slverr_r <= 1'b1;
                end
            endcase
        end
    end

    assign prdata_o = rdata_r;
    assign pready_o = 1'b1;
    assign pslverr_o = slverr_r && psel_i && penable_i;
    assign active_group_o = active_r;
    assign override_active_o = ovr_en_r;
    assign used_mask_o = en_mask;
    assign init_group_o = init_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_ovr_release;
        ovr_en_r ##1 !ovr_en_r;
    endsequence

    a_reset_group_one: assert property (
        @(posedge clk_i) $rose(reset_n_i) |-> active_r == 3'h0)
        else $error("active group not one after reset");

    a_override_apply: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        ovr_ok && used_r != 3'h0 |=> active_r == $past(ovr_idx))
        else $error("override target not applied");

    a_override_hold: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        ovr_en_r && !ovr_ok && used_r != 3'h0 |=> $stable(active_r))
        else $error("group changed while override ignored");

    a_release_holds: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        s_ovr_release ##0 (req == 8'h00 && en_mask[active_r])
        |=> $stable(active_r))
        else $error("group changed after release without request");

    a_release_level: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        s_ovr_release ##0 (hi_lvl[3] && used_r != 3'h0)
        |=> active_r <= $past(hi_lvl[2:0]))
        else $error("level not retaken after release");

    a_group_one_level: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (lvl[0] && !ovr_en_r) [*2] |=> active_r == 3'h0)
        else $error("group one level did not dominate");

    a_level_blocks: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !ovr_en_r && hi_lvl[3] && used_r != 3'h0
        |=> active_r <= $past(hi_lvl[2:0]))
        else $error("lower group passed a static level");

    a_priority_pick: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !ovr_en_r && win[3] && used_r != 3'h0
        |=> active_r == $past(win[2:0]))
        else $error("highest request not selected");

    a_single_idle: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        used_r == 3'h0 |=> active_r == 3'h0)
        else $error("selection moved with one group");

    a_remote_reject: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        rem_wr && rem_range && en_mask[rem_idx] && rem_lower && !ovr_en_r
        |=> status_r[sgs_pkg::ST_LOWER_BIT]
            && active_r != $past(rem_idx))
        else $error("lower remote request not rejected");

    a_init_pulse: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        wr_ctrl |=> init_group_o == (en_mask & ~$past(en_mask))
            ##1 init_group_o == 8'h00 || $past(wr_ctrl))
        else $error("init pulse wrong");

endmodule

// >>> testbench/sgs_pin_model.sv
// Purpose: far side of the request pins, levels and stretched pulses
// Assumes: pulse strobe from the bench lasts one clock
// Notes:   pulses stay high three clocks, above the two the sync needs

`timescale 1ns/1ps

module sgs_pin_model (
    // clock
    input wire logic clk_i,
    // commands from the bench
    input wire logic [7:0] level_i,
    input wire logic [7:0] pulse_i,
    // request pins
    output logic [7:0] req_o
);
    logic [7:0] p1_r = 8'h00;
    logic [7:0] p2_r = 8'h00;
    logic [7:0] p3_r = 8'h00;

    always_ff @(posedge clk_i) begin
        p1_r <= pulse_i;
        p2_r <= p1_r;
        p3_r <= p2_r;
    end
    assign req_o = level_i | p1_r | p2_r | p3_r;
endmodule

// >>> testbench/tb_setting_group_selector.sv
// Purpose: self-checking bench for the setting group selector
// Assumes: zero wait apb slave, three edges from pin rise to output
// Notes:   table of pin cases first, then reset, override and remote

`timescale 1ns/1ps

module tb_setting_group_selector;
    typedef struct {
        logic [2:0] used;
        logic [7:0] lvl;
        logic [7:0] pls;
        logic [2:0] exp;
    } sgs_row_type;

    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [7:0] lvl = 8'h00;
    logic [7:0] pls = 8'h00;
    logic [7:0] req;
    logic [2:0] active_group_o;
    logic override_active_o;
    logic [7:0] used_mask_o;
    logic [7:0] init_group_o;
    logic [7:0] init_last = 8'h00;
    logic [31:0] rd;
    logic apb_err;
    int n_fail = 0;
    int tests_run = 0;

    // ------------------------------------------------------------
    // pin cases, run in order since pulses leave state behind
    // ------------------------------------------------------------
    sgs_row_type rows [9] = '{
        '{3'h7, 8'h00, 8'h08, 3'h3},
        '{3'h7, 8'h84, 8'h00, 3'h2},
        '{3'h7, 8'h80, 8'h00, 3'h7},
        '{3'h7, 8'h01, 8'h20, 3'h0},
        '{3'h7, 8'h10, 8'h40, 3'h4},
        '{3'h7, 8'h20, 8'h80, 3'h5},
        '{3'h1, 8'h00, 8'h08, 3'h0},
        '{3'h0, 8'h02, 8'h00, 3'h0},
        '{3'h3, 8'h00, 8'h08, 3'h3}
    };

    always #2.5 clk_i = ~clk_i;

    sgs_pin_model pins (.clk_i(clk_i), .level_i(lvl), .pulse_i(pls),
        .req_o(req));

    sgs_selector uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .group_req_i(req),
        .active_group_o(active_group_o),
        .override_active_o(override_active_o),
        .used_mask_o(used_mask_o), .init_group_o(init_group_o));

    // last non-zero init pulse, since it stands for one cycle only;
    // cleared by reset so a pulse from an earlier test cannot pass
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            init_last <= 8'h00;
        end else if (init_group_o !== 8'h00) begin
            init_last <= init_group_o;
        end
    end

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        apb_err = pslverr_o;
        check("pready", {31'h0, pready_o}, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask

    task automatic act(input logic [2:0] exp);
        check("active", {29'h0, active_group_o}, {29'h0, exp});
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        cyc(20000);
        n_fail++;
        $display("[ERR] watchdog expired");
        wrap_up();
    end

    initial begin
        cyc(12);
        reset_n_i <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, sgs_pkg::ADDR_CTRL, {25'h0, rows[i].used, 4'h0});
            lvl <= rows[i].lvl;
            pls <= rows[i].pls;
            @(posedge clk_i);
            pls <= 8'h00;
            cyc(8);
            act(rows[i].exp);
            check("mask", {24'h0, used_mask_o},
                  32'((9'h2 << rows[i].used) - 9'h1));
            lvl <= 8'h00;
            cyc(4);
            $display("row %0d done", i);
        end
        // second reset in mid-run
        reset_n_i <= 1'b0;
        cyc(3);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        act(3'h0);
        check("ovr", {31'h0, override_active_o}, 32'h0);
        check("mask", {24'h0, used_mask_o}, 32'h1);
        rdc("ctrl", sgs_pkg::ADDR_CTRL, 32'h0);
        rdc("target", sgs_pkg::ADDR_OVR, 32'h0);
        rdc("remote", sgs_pkg::ADDR_REMOTE, 32'h0);
        apb(1'b1, sgs_pkg::ADDR_CTRL, 32'h30);
        cyc(2);
        check("init", {24'h0, init_last}, 32'h0e);
        apb(1'b1, sgs_pkg::ADDR_CTRL, 32'h50);
        cyc(2);
        check("init", {24'h0, init_last}, 32'h30);
        $display("reset test done");
        // target write without override enable first
        apb(1'b1, sgs_pkg::ADDR_OVR, 32'h6);
        cyc(3);
        act(3'h0);
        rdc("status", sgs_pkg::ADDR_STATUS, 32'h4);
        apb(1'b1, sgs_pkg::ADDR_STATUS, 32'h7);
        apb(1'b1, sgs_pkg::ADDR_CTRL, 32'h51);
        check("ovr", {31'h0, override_active_o}, 32'h1);
        apb(1'b1, sgs_pkg::ADDR_OVR, 32'h6);
        cyc(3);
        act(3'h5);
        pls <= 8'h01;
        @(posedge clk_i);
        pls <= 8'h00;
        cyc(6);
        act(3'h5);
        apb(1'b1, sgs_pkg::ADDR_OVR, 32'h8);
        cyc(3);
        act(3'h5);
        rdc("status", sgs_pkg::ADDR_STATUS, 32'h2);
        apb(1'b1, sgs_pkg::ADDR_CTRL, 32'h50);
        cyc(4);
        act(3'h5);
        apb(1'b1, sgs_pkg::ADDR_CTRL, 32'h51);
        lvl <= 8'h04;
        cyc(6);
        act(3'h5);
        apb(1'b1, sgs_pkg::ADDR_CTRL, 32'h50);
        cyc(1);
        act(3'h2);
        $display("override test done");
        apb(1'b1, sgs_pkg::ADDR_STATUS, 32'h7);
        apb(1'b1, sgs_pkg::ADDR_REMOTE, 32'h5);
        cyc(2);
        act(3'h2);
        rdc("status", sgs_pkg::ADDR_STATUS, 32'h1);
        lvl <= 8'h00;
        cyc(4);
        // group seven lies beyond the used count of six
        apb(1'b1, sgs_pkg::ADDR_REMOTE, 32'h7);
        cyc(1);
        act(3'h2);
        rdc("status", sgs_pkg::ADDR_STATUS, 32'h3);
        apb(1'b1, sgs_pkg::ADDR_REMOTE, 32'h6);
        cyc(1);
        act(3'h5);
        rdc("act_reg", sgs_pkg::ADDR_ACTIVE, 32'h25);
        // lane zero strobe low drops the write
        pstrb <= 4'h0;
        apb(1'b1, sgs_pkg::ADDR_REMOTE, 32'h1);
        pstrb <= 4'hf;
        cyc(1);
        act(3'h5);
        rdc("remote", sgs_pkg::ADDR_REMOTE, 32'h6);
        rdc("unmapped", 8'h20, 32'h0);
        check("slverr", {31'h0, apb_err}, 32'h1);
        $display("remote test done");
        wrap_up();
    end
endmodule
